// ===== dv/ddr3_ctrl_model.sv
`timescale 1ns/1ps
module ddr3_ctrl_model
  import ddr3_init_pkg::*;
(
  input  wire logic ref_clk,
  output cmd_t      cmd
);
  // CKE low, deselected; ODT high so early termination would show
  initial cmd = 23'h3c_0001;

  task automatic down();
    @(negedge ref_clk);
    cmd = 23'h3c_0001;
  endtask

  task automatic issue(input logic [2:0]  op,
                       input logic [2:0]  b,
                       input logic [13:0] a,
                       input int          gap);
    @(negedge ref_clk);
    cmd.cs_n = 1'b0;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = op;
    cmd.ba = b;
    cmd.addr = a;
    // Address is not held after the command, so it toggles
    repeat (gap) begin
      @(negedge ref_clk);
      {cmd.ras_n, cmd.cas_n, cmd.we_n} = CMD_NOP;
      cmd.addr = ~cmd.addr;
    end
  endtask

  task automatic up(input logic o);
    issue(CMD_NOP, 3'h0, 14'h0000, 0);
    @(negedge ref_clk);
    cmd.cke = 1'b1;
    cmd.odt = o;
  endtask

  task automatic load(input logic [13:0] m1, input logic [13:0] m0);
    // A gap of n NOPs puts the next command n+1 cycles on, so every
    // command here lands at the least legal spacing
    repeat (XPR_CYC - 1) @(negedge ref_clk);
    issue(CMD_MRS, 3'h2, 14'h0000, MRD_CYC - 1);
    issue(CMD_MRS, 3'h3, 14'h0000, MRD_CYC - 1);
    issue(CMD_MRS, 3'h1, m1 & 14'h1ffe, MRD_CYC - 1);
    issue(CMD_MRS, 3'h0, (m0 & 14'h1f7f) | 14'h0100,
          MOD_CYC - 1);
    issue(CMD_ZQ, 3'h0, 14'h0400, 2);
  endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  import ddr3_init_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  cmd_t        cmd;
  logic        term_en;
  mr0_t        mode;
  logic [4:0]  read_latency;
  logic        dll_reset;
  logic        dll_locked;
  logic [3:0]  mr_valid;
  logic        init_done;
  err_t        errors;
  int          bad_count = 0;
  int          checks_done = 0;
  int          pulses = 0;
  logic [31:0] seed = 32'h0000_53b8;
  logic [31:0] r;

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (dll_reset === 1'b1) begin
      pulses++;
    end
  end

  ddr3_ctrl_model i_ddr3_ctrl_model (
    .ref_clk(ref_clk),
    .cmd    (cmd)
  );

  // Init wait cut to 50 cycles, DLL and ZQ waits to 20
  ddr3_init_mode_register_setup #(
    .INIT_CYC_P  (17'h0_0032),
    .DLLK_CYC_P  (17'h0_0014),
    .ZQINIT_CYC_P(17'h0_0014)
  ) i_ddr3_init_mode_register_setup (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .cmd         (cmd),
    .term_en     (term_en),
    .mode        (mode),
    .read_latency(read_latency),
    .dll_reset   (dll_reset),
    .dll_locked  (dll_locked),
    .mr_valid    (mr_valid),
    .init_done   (init_done),
    .errors      (errors)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [4:0] exp_cl(input logic [13:0] a);
    return (a[2] ? 5'h0c : 5'h04) + {2'h0, a[6:4]};
  endfunction

  function automatic logic [4:0] exp_rl(input logic [13:0] m1,
                                        input logic [13:0] m0);
    logic [4:0] cl;
    cl = exp_cl(m0);
    case (m1[4:3])
      2'h1: return cl + cl - 5'h01;
      2'h2: return cl + cl - 5'h02;
      default: return cl;
    endcase
  endfunction

  function automatic mr0_t exp_mode(input logic [13:0] a);
    return '{a[1:0], a[3], exp_cl(a), 1'b0, a[11:9], a[12]};
  endfunction

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic do_reset(input int n);
    i_ddr3_ctrl_model.down();
    reset_n = 1'b0;
    repeat (n) @(negedge ref_clk);
    pulses = 0;
    chk({term_en, mr_valid, init_done, dll_reset, errors}, 0);
    reset_n = 1'b1;
  endtask

  task automatic wait_done(input int lim);
    int n = 0;
    while (init_done !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(init_done, 1'b1);
  endtask

  task automatic run_clean(input logic [13:0] m1, input logic [13:0] m0,
                           input logic o);
    do_reset(20);
    repeat (52) @(negedge ref_clk);
    chk(term_en, 1'b0);
    i_ddr3_ctrl_model.up(o);
    i_ddr3_ctrl_model.load(m1, m0);
    chk(term_en, o);
    chk(mr_valid, 4'hf);
    chk(pulses, 1);
    chk(mode, exp_mode(m0));
    chk(read_latency, exp_rl(m1, m0));
    chk(init_done, 1'b0);
    wait_done(80);
    chk(dll_locked, 1'b1);
    chk(errors, 7'h00);
    // Rewrite MR0 while idle in normal operation, with a new CAS latency
    m0 = (m0 ^ 14'h0040) & 14'h1e7f;
    i_ddr3_ctrl_model.issue(CMD_MRS, 3'h0, m0, MRD_CYC);
    chk(mode, exp_mode(m0));
    chk(read_latency, exp_rl(m1, m0));
    chk(pulses, 1);
    $display("clean init done cl=%0d", exp_cl(m0));
  endtask

  initial begin
    do_reset(16);
    // CKE raised inside the 500 us window
    repeat (30) @(negedge ref_clk);
    i_ddr3_ctrl_model.up(1'b1);
    repeat (4) @(negedge ref_clk);
    chk(errors.early, 1'b1);
    $display("early cke test done");
    // MRS inside tXPR, wrong order, tight spacing, early ZQ,
    // then ODT change and CKE drop
    do_reset(20);
    repeat (52) @(negedge ref_clk);
    i_ddr3_ctrl_model.up(1'b0);
    i_ddr3_ctrl_model.issue(CMD_MRS, 3'h2, 14'h0000, XPR_CYC + 2);
    i_ddr3_ctrl_model.issue(CMD_MRS, 3'h3, 14'h0000, 0);
    i_ddr3_ctrl_model.issue(CMD_MRS, 3'h2, 14'h0000, 0);
    // Bank bit 2 high selects no mode register and must be ignored
    i_ddr3_ctrl_model.issue(CMD_MRS, 3'h4, 14'h0000, 0);
    i_ddr3_ctrl_model.issue(CMD_ZQ, 3'h0, 14'h0400, 1);
    chk(mr_valid, 4'hc);
    i_ddr3_ctrl_model.up(1'b1);
    repeat (2) @(negedge ref_clk);
    i_ddr3_ctrl_model.down();
    repeat (3) @(negedge ref_clk);
    chk(errors, 7'h3f);
    chk(init_done, 1'b0);
    $display("violation test done");
    // Corner: largest read latency that fits, then random settings
    run_clean(14'h0008, 14'h0044, 1'b1);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      run_clean(r[13:0], r[27:14] & 14'h3ffb, r[31]);
    end
    close_out();
  end
endmodule

// ===== hdl/ddr3_init_mode_register_setup.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Controller holds reset low 200 us after power is stable.
// (RULE2) Controller drives CKE low 10 ns before releasing reset.
// (RULE3) Device initialises internally for 500 us before CKE may rise.
// (RULE4) Controller runs the clock max(10 ns, 5 tCK) before CKE rises.
// (RULE5) A NOP or deselect is registered before CKE first rises.
// (RULE6) CKE stays high from first rise until initialisation completes.
// (RULE7) Termination stays off in reset and until CKE is registered high.
// (RULE8) ODT is held static from CKE high until initialisation ends.
// (RULE9) First MRS waits tXPR after CKE is registered high.
// (RULE10) Mode registers load in order MR2, MR3, MR1, MR0 by bank address.
// (RULE11) MR1 write enables the DLL, then MR0 write requests DLL reset.
// (RULE12) Long ZQ calibration follows, then wait for tDLLK and tZQinit.
// (RULE13) Warm reset: 100 ns low, then rerun from the 500 us wait.
// (RULE14) Mode registers are undefined after reset until fully written.
// (RULE15) Every MRS supplies all address fields of the target register.
// (RULE16) At least tMRD separates two MRS commands.
// (RULE17) At least tMOD from MRS to any command other than NOP/deselect; the tMOD check here also exempts MRS.
// (RULE18) In normal operation MRS is issued only while idle with CKE high.
// (RULE19) Command with CS, RAS, CAS, WE and BA all low writes MR0.
// (RULE20) MR0 A2 and A6..A4 give CAS latency; read latency is AL plus CL.
// (RULE21) MR0 A7 must stay zero; one selects an unsupported test mode.
// (RULE22) Programmed write recovery covers tWR/tCK rounded up.
// (RULE23) tXPR, tMRD, tMOD, tDLLK and tZQinit are configurable counts.
module ddr3_init_mode_register_setup
  import ddr3_init_pkg::*;
#(
  parameter logic [TMR_W-1:0] INIT_CYC_P   = TMR_W'(INIT_CYC),
  parameter logic [TMR_W-1:0] XPR_CYC_P    = TMR_W'(XPR_CYC),
  parameter logic [TMR_W-1:0] MRD_CYC_P    = TMR_W'(MRD_CYC),
  parameter logic [TMR_W-1:0] MOD_CYC_P    = TMR_W'(MOD_CYC),
  parameter logic [TMR_W-1:0] DLLK_CYC_P   = TMR_W'(DLLK_CYC),
  parameter logic [TMR_W-1:0] ZQINIT_CYC_P = TMR_W'(ZQINIT_CYC)
) (
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  input  wire cmd_t  cmd,
  output logic       term_en,
  output mr0_t       mode,
  output logic [4:0] read_latency,
  output logic       dll_reset,
  output logic       dll_locked,
  output logic [3:0] mr_valid,
  output logic       init_done,
  output err_t       errors
);

  init_state_t state_r;
  logic        cke_prev_r;
  logic        odt_prev_r;
  logic        cke_seen_r;
  logic        term_en_r;
  logic [13:0] mr_r [4];
  logic [3:0]  mr_valid_r;
  mr0_t        mode_r;
  logic [4:0]  read_latency_r;
  logic        dll_reset_r;
  logic        dll_seen_r;
  logic [2:0]  seq_idx_r;
  err_t        err_r;
  logic       phase_busy, mrd_busy, mod_busy, dll_busy, zq_busy;
  logic       cmd_ok, mrs_cmd, mrs_take, zq_take, mrs_state, init_hold;
  logic       dll_start;
  logic [2:0] op;
  logic [1:0] mr_sel, mr_expect;
  logic [4:0] al;
  assign op        = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  // Commands count only with CKE high on this and the previous edge
  assign cmd_ok    = cke_prev_r & cmd.cke & ~cmd.cs_n;
  assign mrs_state = (state_r == ST_MRS) || (state_r == ST_CAL) ||
                     (state_r == ST_READY);
  assign mrs_cmd   = cmd_ok && (op == CMD_MRS) && !cmd.ba[2];
  assign mrs_take  = mrs_cmd && mrs_state;
  assign zq_take   = cmd_ok && (op == CMD_ZQ) && cmd.addr[A_ZQ_LONG] &&
                     mrs_state;
  assign mr_sel    = cmd.ba[1:0];
  assign mr_expect = MR_SEQ[{seq_idx_r[1:0], 1'b0} +: 2];
  assign init_hold = (state_r == ST_XPR) || (state_r == ST_MRS) ||
                     (state_r == ST_CAL);
  assign dll_start = mrs_take && (mr_sel == 2'h0) && cmd.addr[A_DLL_RST];
  // Internal init and the tXPR wait never overlap, so they share a counter.
  // tXPR ends in a state change and loads two short; tMRD and tMOD gate
  // commands directly and load one short, so an on-time command passes.
  delay_timer u_phase (.ref_clk(ref_clk), .reset_n(reset_n),
    .start((state_r == ST_RESET) || ((state_r == ST_WAIT_CKE) && cmd.cke)),
    .load((state_r == ST_RESET) ? INIT_CYC_P : XPR_CYC_P - TMR_W'(2)),
    .busy(phase_busy)); // RULE3
  delay_timer u_mrd (.ref_clk(ref_clk), .reset_n(reset_n),
    .start(mrs_take), .load(MRD_CYC_P - TMR_W'(1)), .busy(mrd_busy));
  delay_timer u_mod (.ref_clk(ref_clk), .reset_n(reset_n),
    .start(mrs_take), .load(MOD_CYC_P - TMR_W'(1)), .busy(mod_busy));
  delay_timer u_dll (.ref_clk(ref_clk), .reset_n(reset_n),
    .start(dll_start), .load(DLLK_CYC_P), .busy(dll_busy));
  delay_timer u_zq (.ref_clk(ref_clk), .reset_n(reset_n),
    .start(zq_take), .load(ZQINIT_CYC_P), .busy(zq_busy));
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_RESET;
    end else begin
      case (state_r)
        ST_RESET:    state_r <= ST_INIT;
        ST_INIT:     if (!phase_busy) state_r <= ST_WAIT_CKE; // RULE3
        ST_WAIT_CKE: if (cmd.cke) state_r <= ST_XPR;
        ST_XPR:      if (!phase_busy) state_r <= ST_MRS;
        ST_MRS:      if (zq_take && seq_idx_r == SEQ_END) state_r <= ST_CAL;
        ST_CAL: begin
          if (!dll_busy && !zq_busy && dll_seen_r && (&mr_valid_r)) begin
            state_r <= ST_READY; // RULE14
          end
        end
        ST_READY:    state_r <= ST_READY;
        default:     state_r <= ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_prev_r <= 1'b0;
      odt_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= cmd.cke;
      odt_prev_r <= cmd.odt;
    end
  end

  // Termination follows ODT only once CKE has been registered high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_seen_r <= 1'b0;
      term_en_r  <= 1'b0;
    end else begin
      if ((state_r == ST_WAIT_CKE) && cmd.cke) cke_seen_r <= 1'b1;
      term_en_r <= cke_seen_r & cmd.odt; // RULE7
    end
  end

  // Writes from ST_MRS onward land in the selected register whatever the order and tMRD checks say
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) mr_r[i] <= 14'h0000;
      mr_valid_r <= 4'h0; // RULE14
    end else if (mrs_take) begin
      mr_r[mr_sel] <= cmd.addr;
      // DLL reset is self-clearing, so it is never kept
      if (mr_sel == 2'h0) mr_r[0][A_DLL_RST] <= 1'b0;
      mr_valid_r[mr_sel] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= '0;
    end else if (mrs_take && mr_sel == 2'h0) begin // RULE19
      mode_r.burst_len   <= cmd.addr[A_BL +: 2];
      mode_r.burst_type  <= cmd.addr[A_BT];
      mode_r.cas_latency <= cl_decode(cmd.addr); // RULE20
      mode_r.test_mode   <= cmd.addr[A_TEST];
      mode_r.wr_code     <= cmd.addr[A_WR +: 3];
      mode_r.ppd_fast    <= cmd.addr[A_PPD];
    end
  end

  // Additive latency code from MR1: 0, CL-1, CL-2; the spare code reads 0
  always_comb begin
    case (mr_r[1][A_AL +: 2])
      2'h1:    al = mode_r.cas_latency - 5'h01;
      2'h2:    al = mode_r.cas_latency - 5'h02;
      default: al = 5'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_latency_r <= 5'h00;
    end else begin
      read_latency_r <= al + mode_r.cas_latency; // RULE20
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_reset_r <= 1'b0;
      dll_seen_r  <= 1'b0;
    end else begin
      dll_reset_r <= dll_start;
      if (dll_start) dll_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_idx_r <= 3'h0;
    end else if (mrs_take && state_r == ST_MRS && seq_idx_r != SEQ_END) begin
      seq_idx_r <= seq_idx_r + 3'h1;
    end
  end

  // Sticky protocol checks on the controller; only reset clears them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r <= '0;
    end else begin
      if (state_r == ST_INIT && cmd.cke) err_r.early <= 1'b1; // RULE3
      if (mrs_cmd && (state_r == ST_XPR || state_r == ST_WAIT_CKE)) begin
        err_r.xpr <= 1'b1; // RULE9
      end
      if (mrs_take && state_r == ST_MRS &&
          (seq_idx_r == SEQ_END || mr_sel != mr_expect)) begin
        err_r.order <= 1'b1; // RULE10
      end
      if (zq_take && state_r == ST_MRS && seq_idx_r != SEQ_END) begin
        err_r.order <= 1'b1; // RULE12
      end
      if (mrs_take && mrd_busy) err_r.mrd <= 1'b1; // RULE16
      if (cmd_ok && mod_busy && op != CMD_NOP && op != CMD_MRS) begin
        err_r.mod <= 1'b1; // RULE17
      end
      if (init_hold && !cmd.cke) err_r.cke <= 1'b1; // RULE6
      if (init_hold && cmd.odt != odt_prev_r) err_r.odt <= 1'b1; // RULE8
    end
  end

  assign term_en      = term_en_r;
  assign mode         = mode_r;
  assign read_latency = read_latency_r;
  assign dll_reset    = dll_reset_r;
  assign dll_locked   = dll_seen_r & ~dll_busy;
  assign mr_valid     = mr_valid_r;
  assign init_done    = (state_r == ST_READY);
  assign errors       = err_r;
  // Cycles spent in the internal initialisation state
  logic [TMR_W-1:0] rel_cnt_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_cnt_r <= '0;
    end else if (state_r == ST_INIT) begin
      rel_cnt_r <= rel_cnt_r + TMR_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_init_wait;
    (state_r == ST_WAIT_CKE && $past(state_r) == ST_INIT)
      |-> rel_cnt_r == INIT_CYC_P + TMR_W'(1);
  endproperty
  a_init_wait: assert property (p_init_wait) // RULE3
    else $error("left internal init early or late");
  property p_term_off;
    $rose(term_en_r) |-> cke_seen_r && $past(cmd.odt);
  endproperty
  a_term_off: assert property (p_term_off) // RULE7
    else $error("termination on before CKE registered");
  property p_mr0_write;
    (mrs_take && mr_sel == 2'h0)
      |=> mr_valid_r[0] && mr_r[0][7:0] == $past(cmd.addr[7:0]);
  endproperty
  a_mr0_write: assert property (p_mr0_write) // RULE19
    else $error("MR0 write not stored");
  property p_cl;
    (mrs_take && mr_sel == 2'h0)
      |=> mode_r.cas_latency == cl_decode($past(cmd.addr))
          ##1 read_latency_r == al + mode_r.cas_latency;
  endproperty
  a_cl: assert property (p_cl) // RULE20
    else $error("CAS or read latency wrong");
  property p_ready_valid;
    $rose(init_done) |-> (&mr_valid_r) && dll_locked;
  endproperty
  a_ready_valid: assert property (p_ready_valid) // RULE14
    else $error("ready with registers unwritten");
  property p_dll_pulse;
    dll_start |=> dll_reset_r ##1 !dll_reset_r && !mr_r[0][A_DLL_RST];
  endproperty
  a_dll_pulse: assert property (p_dll_pulse) // RULE11
    else $error("DLL reset not self-clearing");
  property p_mrd;
    (mrs_take && mrd_busy) |=> err_r.mrd [*3];
  endproperty
  a_mrd: assert property (p_mrd) // RULE16
    else $error("tMRD violation not flagged");
  property p_cke_hold;
    (init_hold && !cmd.cke) |=> err_r.cke;
  endproperty
  a_cke_hold: assert property (p_cke_hold) // RULE6
    else $error("CKE drop not flagged");
  property p_order;
    (mrs_take && state_r == ST_MRS && mr_sel != mr_expect) |=> err_r.order;
  endproperty
  a_order: assert property (p_order) // RULE10
    else $error("mode register order not flagged");
  c_ready: cover property ($rose(init_done));
  c_dll: cover property (dll_start ##[1:600] dll_locked);
  c_test: cover property (mrs_take && mr_sel == 2'h0 && cmd.addr[A_TEST]);

endmodule

// ===== hdl/ddr3_init_pkg.sv
package ddr3_init_pkg;

  // Clock and time figures
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_INIT_US     = 500;
  // Least time: round up to whole cycles
  localparam int INIT_CYC = (T_INIT_US * 1000000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int XPR_CYC    = 16;
  localparam int MRD_CYC    = 4;
  localparam int MOD_CYC    = 12;
  localparam int DLLK_CYC   = 512;
  localparam int ZQINIT_CYC = 512;
  localparam int TMR_W      = 17;

  // Address bit positions
  localparam int A_BL      = 0;
  localparam int A_CL_LO   = 2;
  localparam int A_BT      = 3;
  localparam int A_AL      = 3;
  localparam int A_CL_HI   = 4;
  localparam int A_TEST    = 7;
  localparam int A_DLL_RST = 8;
  localparam int A_WR      = 9;
  localparam int A_ZQ_LONG = 10;
  localparam int A_PPD     = 12;

  // Command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_ZQ  = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Load order MR2, MR3, MR1, MR0, two bits per step from the low end
  localparam logic [7:0] MR_SEQ  = 8'h1e;
  localparam logic [2:0] SEQ_END = 3'h4;

  localparam logic [4:0] CL_BASE_LO = 5'h04;
  localparam logic [4:0] CL_BASE_HI = 5'h0c;

  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_INIT     = 3'b001,
    ST_WAIT_CKE = 3'b010,
    ST_XPR      = 3'b011,
    ST_MRS      = 3'b100,
    ST_CAL      = 3'b101,
    ST_READY    = 3'b110
  } init_state_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic        odt;
  } cmd_t;

  typedef struct packed {
    logic [1:0] burst_len;
    logic       burst_type;
    logic [4:0] cas_latency;
    logic       test_mode;
    logic [2:0] wr_code;
    logic       ppd_fast;
  } mr0_t;

  typedef struct packed {
    logic early;
    logic xpr;
    logic order;
    logic mrd;
    logic mod;
    logic cke;
    logic odt;
  } err_t;

  function automatic logic [4:0] cl_decode(input logic [13:0] a);
    logic [4:0] base;
    base = a[A_CL_LO] ? CL_BASE_HI : CL_BASE_LO;
    return base + {2'h0, a[A_CL_HI +: 3]};
  endfunction

endpackage

// ===== hdl/delay_timer.sv
`timescale 1ns/1ps
module delay_timer
  import ddr3_init_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= load;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign busy = (cnt_r != '0);

endmodule
